// ### bench/uart_control_and_baud_gen_tb.sv
// Purpose: Self-checking bench for the serial port control block.
// Assumes: Divisor 1, so one bit is 32 clocks.
// Notes: The far end model sends and collects frames.
module uart_control_and_baud_gen_tb
	import uart_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT = 32;
	localparam logic [7:0] ST = IDX_STATUS;
	localparam logic [7:0] CT = IDX_CONTROL;
	localparam logic [7:0] DT = IDX_DATA;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	apb_req_t apb_req = '0;
	logic [31:0] prdata;
	logic pready, pslverr, rx_done_irq, tx_done_irq, tx_empty_irq, rxd, txd, txd_oe;
	logic global_irq_en = 1'b0;
	logic tx_done_vec_ack = 1'b0;
	int error_cnt = 0;
	int n_tests = 0;
	logic last_err = 1'b0;
	uart_control_and_baud_gen dut (.ref_clk, .arst_n, .apb_req, .prdata, .pready, .pslverr,
		.global_irq_en, .tx_done_vec_ack, .rx_done_irq, .tx_done_irq, .tx_empty_irq,
		.rxd, .txd, .txd_oe);
	uart_far_end #(.BIT_CLKS(BIT)) far (.ref_clk, .txd, .rxd);
	always #2.5 ref_clk = ~ref_clk;
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// The request stands unchanged until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
		apb_req <= '{1'b1, 1'b0, w, {a, 2'h0}, wd};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		if (k >= 64) error_cnt++;
		rd = prdata;
		last_err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		apb(1'b1, a, d, rd);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] rd;
		apb(1'b0, a, 32'h0, rd);
		chk(nm, e, rd);
	endtask
	task automatic t_regs;
		rc("status", ST, 32'h20);
		rc("control", CT, 32'h0);
		wr(IDX_BAUD_HIGH, 32'hFF);
		rc("baud_high", IDX_BAUD_HIGH, 32'h0F);
		wr(IDX_BAUD_HIGH, 32'h0);
		wr(IDX_BAUD_LOW, 32'h01);
		rc("baud_low", IDX_BAUD_LOW, 32'h01);
		wr(ST, 32'hFF);
		rc("status_wr", ST, 32'h21);
		wr(ST, 32'h0);
		rc("unmapped", 8'h3F, 32'h0);
		chk("slverr", 32'h1, 32'(last_err));
	endtask
	task automatic t_tx;
		global_irq_en <= 1'b1;
		wr(CT, 32'h38);
		chk("empty_irq", 32'h1, 32'(tx_empty_irq));
		chk("txd_oe", 32'h1, 32'(txd_oe));
		wr(DT, 32'h96);
		wr(DT, 32'h4B);
		rc("busy", ST, 32'h0);
		wr(CT, 32'h50);
		for (int k = 0; k < 30 * BIT && far.got_q.size() < 2; k++) @(posedge ref_clk);
		repeat (2 * BIT) @(posedge ref_clk);
		chk("tx_count", 32'h2, 32'(far.got_q.size()));
		chk("tx_first", 32'h96, 32'(far.got_q[0]));
		chk("tx_second", 32'h4B, 32'(far.got_q[1]));
		rc("tx_status", ST, 32'h60);
		chk("done_irq", 32'h1, 32'(tx_done_irq));
		tx_done_vec_ack <= 1'b1;
		@(posedge ref_clk);
		tx_done_vec_ack <= 1'b0;
		@(posedge ref_clk);
		rc("ack_status", ST, 32'h20);
	endtask
	task automatic t_rx;
		wr(CT, 32'h90);
		far.send(9'h03C, 8, 1'b1);
		rc("rx_status", ST, 32'hA0);
		chk("rx_irq", 32'h1, 32'(rx_done_irq));
		rc("rx_data", DT, 32'h3C);
		rc("rx_clear", ST, 32'h20);
		far.send(9'h011, 8, 1'b0);
		far.send(9'h022, 8, 1'b0);
		rc("ovr_status", ST, 32'hB8);
		rc("ovr_data", DT, 32'h11);
		far.send(9'h05A, 8, 1'b1);
		rc("ok_status", ST, 32'hA0);
		rc("ok_data", DT, 32'h5A);
		wr(ST, 32'h01);
		far.send(9'h033, 8, 1'b0);
		rc("md_skip", ST, 32'h21);
		far.send(9'h044, 8, 1'b1);
		rc("md_addr", DT, 32'h44);
		wr(ST, 32'h0);
		wr(CT, 32'h94);
		far.send(9'h1A5, 9, 1'b1);
		rc("nine_ctl", CT, 32'h96);
		rc("nine_data", DT, 32'hA5);
		wr(CT, 32'h0);
		far.send(9'h000, 8, 1'b0);
		rc("off_status", ST, 32'h20);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs;
		t_tx;
		t_rx;
		tally_and_finish;
	end
	// The run takes under 4000 clocks, so the 60000-clock limit is generous.
	initial begin
		#300000;
		error_cnt++;
		tally_and_finish;
	end
endmodule

// ### bench/uart_ctl_props.sv
// Purpose: Port-level checks for the serial port control block.
// Assumes: Sees only the top module's ports.
// Notes: Any divisor gives at least sixteen clocks per bit.
module uart_ctl_props
	import uart_ctl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// APB slave
	input wire apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Core interrupt side
	input wire logic global_irq_en,
	input wire logic tx_done_vec_ack,
	input wire logic rx_done_irq,
	input wire logic tx_done_irq,
	input wire logic tx_empty_irq,
	// Serial pins
	input wire logic rxd,
	input wire logic txd,
	input wire logic txd_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	property p_rx_irq; rx_done_irq |-> global_irq_en; endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq while masked");
	property p_tx_irq; tx_done_irq |-> global_irq_en; endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq while masked");
	property p_em_irq; tx_empty_irq |-> global_irq_en; endproperty
	a_em_irq: assert property (p_em_irq) else $error("empty irq while masked");
	property p_low; $fell(txd) |=> !txd [*8]; endproperty
	a_low: assert property (p_low) else $error("low bit too short");
	property p_high; $rose(txd) |=> txd [*8]; endproperty
	a_high: assert property (p_high) else $error("high bit too short");
	property p_oe; !txd |-> txd_oe; endproperty
	a_oe: assert property (p_oe) else $error("txd low undriven");
	// A finishing frame may set the flag again in the ack cycle, so only idle lines count.
	property p_ack; tx_done_vec_ack && !txd_oe |=> !tx_done_irq; endproperty
	a_ack: assert property (p_ack) else $error("tx done kept after ack");
	property p_rsv; apb_req.psel && !apb_req.penable && !apb_req.pwrite
		&& apb_req.paddr == {IDX_STATUS, 2'h0} |=> prdata[2:1] == 2'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
endmodule
bind uart_control_and_baud_gen uart_ctl_props u_props (.ref_clk, .arst_n, .apb_req, .prdata,
	.pready, .pslverr, .global_irq_en, .tx_done_vec_ack, .rx_done_irq, .tx_done_irq,
	.tx_empty_irq, .rxd, .txd, .txd_oe);

// ### bench/uart_far_end.sv
// Purpose: Remote serial transceiver on the port pins.
// Assumes: One bit lasts BIT_CLKS clocks.
// Notes: Frames with a bad stop bit are not collected.
module uart_far_end #(
	parameter int BIT_CLKS = 32
) (
	// Clock
	input wire logic ref_clk,
	// Serial pins
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial rxd = 1'b1;
	// Start low, data LSB first, then the chosen stop level.
	task automatic send(input logic [8:0] d, input int n, input logic stp);
		rxd <= 1'b0;
		repeat (BIT_CLKS) @(posedge ref_clk);
		for (int i = 0; i < n; i++) begin
			rxd <= d[i];
			repeat (BIT_CLKS) @(posedge ref_clk);
		end
		rxd <= stp;
		repeat (BIT_CLKS) @(posedge ref_clk);
		rxd <= 1'b1;
		repeat (BIT_CLKS) @(posedge ref_clk);
	endtask
	// Mid-bit sampling keeps clear of the edges where txd moves.
	always begin
		@(negedge txd);
		repeat (BIT_CLKS / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge ref_clk);
			sh[i] = txd;
		end
		repeat (BIT_CLKS) @(posedge ref_clk);
		if (txd === 1'b1) got_q.push_back(sh);
	end
endmodule

// ### inc/uart_ctl_pkg.sv
// Purpose: Shared constants and types for the serial port control block.
// Assumes: APB register access, one 32-bit word per register.
// Notes: Register byte address is four times the register index.
package uart_ctl_pkg;
	// Register indices and the byte address that each one takes.
	localparam logic [7:0] IDX_BAUD_HIGH = 8'h03;
	localparam logic [7:0] IDX_BAUD_LOW = 8'h09;
	localparam logic [7:0] IDX_CONTROL = 8'h0A;
	localparam logic [7:0] IDX_STATUS = 8'h0B;
	localparam logic [7:0] IDX_DATA = 8'h0C;
	localparam int ADDR_SHIFT = 2;
	localparam int ADDR_W = 10;

	// Status register fields.
	localparam int ST_RX_DONE = 7;
	localparam int ST_TX_DONE = 6;
	localparam int ST_TX_EMPTY = 5;
	localparam int ST_FRAME_ERR = 4;
	localparam int ST_OVERRUN = 3;
	localparam int ST_MULTIDROP = 0;

	// Control register fields.
	localparam int CT_RX_IRQ_EN = 7;
	localparam int CT_TX_IRQ_EN = 6;
	localparam int CT_EMPTY_IRQ_EN = 5;
	localparam int CT_RX_ON = 4;
	localparam int CT_TX_ON = 3;
	localparam int CT_NINE_BIT = 2;
	localparam int CT_RX_NINTH = 1;
	localparam int CT_TX_NINTH = 0;

	// Reset values and field widths.
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam int BAUD_HIGH_W = 4;
	localparam int DIV_W_DOC = 12;

	// Oversampling and the three majority samples, counted from zero.
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;

	// Frame lengths in bit times, start and stop included, and the receive end points.
	localparam logic [3:0] TX_BITS_EIGHT = 4'hA;
	localparam logic [3:0] TX_BITS_NINE = 4'hB;
	localparam logic [3:0] TX_BITS_LAST = 4'h1;
	localparam logic [3:0] RX_LAST_EIGHT = 4'h9;
	localparam logic [3:0] RX_LAST_NINE = 4'hA;
	localparam logic [3:0] RX_OVS_FIRST = 4'h1;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum {RX_IDLE, RX_BITS} rx_state_t;
endpackage

// ### verilog/uart_control_and_baud_gen.sv
// Purpose: Control, status, baud generator, transmitter and receiver of an async serial port.
// Assumes: Receive pin is synchronous to ref_clk; pready is always high (zero wait states).
// Notes: Unmapped indices read zero; an unmapped index or unaligned address answers with pslverr.

module uart_control_and_baud_gen
	import uart_ctl_pkg::*;
#(
	parameter int DIV_W = DIV_W_DOC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// APB slave
	input wire apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core interrupt side
	input wire logic global_irq_en,
	input wire logic tx_done_vec_ack,
	output logic rx_done_irq,
	output logic tx_done_irq,
	output logic tx_empty_irq,
	// Serial pins
	input wire logic rxd,
	output logic txd,
	output logic txd_oe
);
	if (DIV_W != DIV_W_DOC) begin : g_check
		$error("DIV_W must match the twelve-bit divisor layout");
	end

	logic wr_en;
	logic rd_en;
	logic [7:0] widx;
	logic [7:0] wdat;
	logic hit;
	logic data_wr;
	logic data_rd;
	logic [7:0] baud_high_q;
	logic [7:0] baud_low_q;
	logic [7:0] ctrl_q;
	logic [7:0] tx_buf_q;
	logic tx_ninth_q;
	logic tx_empty_q;
	logic tx_done_q;
	logic rx_done_q;
	logic frame_err_q;
	logic overrun_q;
	logic mdrop_q;
	logic [7:0] rx_data_q;
	logic rx_ninth_q;
	logic [DIV_W-1:0] div_cnt_q;
	logic tick;
	tx_state_t tx_st_q;
	logic [3:0] tx_ovs_q;
	logic [3:0] tx_bits_q;
	logic [10:0] tx_sh_q;
	logic tx_load;
	logic tx_bit_end;
	logic tx_finish;
	rx_state_t rx_st_q;
	logic [3:0] rx_ovs_q;
	logic [3:0] rx_bits_q;
	logic [8:0] rx_sh_q;
	logic [1:0] smp_q;
	logic maj;
	logic rx_decide;
	logic rx_last;
	logic rx_take;
	logic [7:0] rx_byte;
	logic rx_addr;
	logic nine;

	assign nine = ctrl_q[CT_NINE_BIT];
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
	assign widx = apb_req.paddr[ADDR_SHIFT +: 8];
	assign wdat = apb_req.pwdata[7:0];
	assign hit = (apb_req.paddr[ADDR_SHIFT-1:0] == '0) &&
		(widx == IDX_BAUD_HIGH || widx == IDX_BAUD_LOW || widx == IDX_CONTROL ||
		widx == IDX_STATUS || widx == IDX_DATA);
	assign data_wr = wr_en && hit && widx == IDX_DATA;
	assign data_rd = rd_en && hit && widx == IDX_DATA;
	assign pready = 1'b1;
	assign pslverr = apb_req.psel & apb_req.penable & ~hit;

	// Read data is registered so it is steady for the whole access phase.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
		end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			prdata <= '0;
			case (widx)
				IDX_BAUD_HIGH: prdata[7:0] <= {4'h0, baud_high_q[3:0]};
				IDX_BAUD_LOW: prdata[7:0] <= baud_low_q;
				IDX_CONTROL: prdata[7:0] <= {ctrl_q[7:2], rx_ninth_q, 1'b0};
				IDX_STATUS: prdata[7:0] <= {rx_done_q, tx_done_q, tx_empty_q, frame_err_q,
					overrun_q, 2'b00, mdrop_q};
				IDX_DATA: prdata[7:0] <= rx_data_q;
				default: prdata <= '0;
			endcase
		end
	end

	// Control and divisor registers; the ninth transmit bit is write-only.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CONTROL_RST;
			baud_high_q <= BAUD_RST;
			baud_low_q <= BAUD_RST;
			tx_ninth_q <= 1'b0;
			mdrop_q <= 1'b0;
		end else if (wr_en && hit) begin
			case (widx)
				IDX_BAUD_HIGH: baud_high_q <= {4'h0, wdat[BAUD_HIGH_W-1:0]};
				IDX_BAUD_LOW: baud_low_q <= wdat;
				IDX_CONTROL: begin
					ctrl_q <= {wdat[7:2], 2'b00};
					tx_ninth_q <= wdat[CT_TX_NINTH];
				end
				IDX_STATUS: mdrop_q <= wdat[ST_MULTIDROP];
				default: ;
			endcase
		end
	end

	// Baud divider: one oversampling tick every divisor plus one clocks.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_q <= '0;
		end else if (div_cnt_q >= {baud_high_q[BAUD_HIGH_W-1:0], baud_low_q}) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_q + 1'b1;
		end
	end
	assign tick = (div_cnt_q >= {baud_high_q[BAUD_HIGH_W-1:0], baud_low_q});

	// Loading is held off during a data write so a fresh write is never lost.
	assign tx_load = ~tx_empty_q && ~data_wr &&
		((tx_st_q == TX_IDLE && ctrl_q[CT_TX_ON]) || tx_finish);
	assign tx_bit_end = (tx_st_q == TX_SHIFT) && tick && (tx_ovs_q == OVS_LAST);
	assign tx_finish = tx_bit_end && (tx_bits_q == TX_BITS_LAST);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_buf_q <= '0;
		end else if (data_wr) begin
			tx_buf_q <= wdat;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_empty_q <= 1'b1;
		end else if (tx_load) begin
			tx_empty_q <= 1'b1;
		end else if (data_wr) begin
			tx_empty_q <= 1'b0;
		end
	end

	// Transmit shifter: frame is start, data LSB first, optional ninth bit, stop.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= '1;
			tx_ovs_q <= '0;
			tx_bits_q <= '0;
		end else if (tx_load) begin
			tx_st_q <= TX_SHIFT;
			tx_ovs_q <= '0;
			if (nine) begin
				tx_sh_q <= {1'b1, tx_ninth_q, tx_buf_q, 1'b0};
				tx_bits_q <= TX_BITS_NINE;
			end else begin
				tx_sh_q <= {2'b11, tx_buf_q, 1'b0};
				tx_bits_q <= TX_BITS_EIGHT;
			end
		end else if (tx_finish) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= '1;
		end else if (tx_st_q == TX_SHIFT && tick) begin
			tx_ovs_q <= tx_ovs_q + 1'b1;
			if (tx_bit_end) begin
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				tx_bits_q <= tx_bits_q - 1'b1;
			end
		end
	end
	assign txd = tx_sh_q[0];
	assign txd_oe = ctrl_q[CT_TX_ON] | (tx_st_q == TX_SHIFT);

	// Transmit-complete: setting beats either clear.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_done_q <= 1'b0;
		end else if (tx_finish && tx_empty_q && ctrl_q[CT_RX_ON]) begin
			tx_done_q <= 1'b1;
		end else if (tx_done_vec_ack ||
			(wr_en && hit && widx == IDX_STATUS && wdat[ST_TX_DONE])) begin
			tx_done_q <= 1'b0;
		end
	end

	// Receiver: sample counter runs from the first low sample of the start bit.
	assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & rxd) | (smp_q[1] & rxd);
	assign rx_decide = (rx_st_q == RX_BITS) && tick && (rx_ovs_q == SMP_C);
	assign rx_last = rx_bits_q == (nine ? RX_LAST_NINE : RX_LAST_EIGHT);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			smp_q <= '0;
		end else if (tick && rx_st_q == RX_BITS && rx_ovs_q == SMP_A) begin
			smp_q[0] <= rxd;
		end else if (tick && rx_st_q == RX_BITS && rx_ovs_q == SMP_B) begin
			smp_q[1] <= rxd;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st_q <= RX_IDLE;
			rx_ovs_q <= '0;
			rx_bits_q <= '0;
			rx_sh_q <= '0;
		end else if (!ctrl_q[CT_RX_ON]) begin
			rx_st_q <= RX_IDLE;
		end else if (tick) begin
			case (rx_st_q)
				RX_IDLE: begin
					if (!rxd) begin
						rx_st_q <= RX_BITS;
						rx_ovs_q <= RX_OVS_FIRST;
						rx_bits_q <= '0;
					end
				end
				RX_BITS: begin
					rx_ovs_q <= rx_ovs_q + 1'b1;
					if (rx_decide) begin
						rx_bits_q <= rx_bits_q + 1'b1;
						if (rx_bits_q == 4'h0 && maj) begin
							rx_st_q <= RX_IDLE;
						end else if (rx_last) begin
							rx_st_q <= RX_IDLE;
						end else if (rx_bits_q != 4'h0) begin
							rx_sh_q <= {maj, rx_sh_q[8:1]};
						end
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	assign rx_byte = nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
	assign rx_addr = nine ? rx_sh_q[8] : maj;
	assign rx_take = rx_decide && rx_last && ctrl_q[CT_RX_ON] &&
		(!mdrop_q || rx_addr);

	// Character transfer into the data register, or an overrun if still unread.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_data_q <= '0;
			rx_ninth_q <= 1'b0;
			frame_err_q <= 1'b0;
			overrun_q <= 1'b0;
		end else if (rx_take) begin
			if (rx_done_q && !data_rd) begin
				overrun_q <= 1'b1;
			end else begin
				rx_data_q <= rx_byte;
				rx_ninth_q <= nine ? rx_sh_q[8] : rx_ninth_q;
				frame_err_q <= ~maj;
				overrun_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_done_q <= 1'b0;
		end else if (rx_take) begin
			rx_done_q <= 1'b1;
		end else if (data_rd) begin
			rx_done_q <= 1'b0;
		end
	end

	assign rx_done_irq = global_irq_en & ctrl_q[CT_RX_IRQ_EN] & rx_done_q;
	assign tx_done_irq = global_irq_en & ctrl_q[CT_TX_IRQ_EN] & tx_done_q;
	assign tx_empty_irq = global_irq_en & ctrl_q[CT_EMPTY_IRQ_EN] & tx_empty_q;
endmodule
